// *** verilog/pltm_pkg.sv ***
package pltm_pkg;
  localparam int PLTM_IN_W   = 11;
  localparam int PLTM_OUT_W  = 9;
  localparam int PLTM_DEPTH  = 2048;
  localparam int PLTM_PIX_W  = 16;
  localparam int PLTM_ADDR_W = 4;
  localparam int PLTM_DATA_W = 32;
  localparam int PLTM_CHAN_N = 3;

  localparam logic [3:0] PLTM_OFS_CTRL     = 4'h0;
  localparam logic [3:0] PLTM_OFS_SELECT   = 4'h1;
  localparam logic [3:0] PLTM_OFS_INDEX    = 4'h2;
  localparam logic [3:0] PLTM_OFS_VALUE    = 4'h3;
  localparam logic [3:0] PLTM_OFS_BULK     = 4'h4;
  localparam logic [3:0] PLTM_OFS_BULK_RST = 4'h5;
  localparam logic [3:0] PLTM_OFS_STATUS   = 4'h6;

  localparam int PLTM_CTRL_ACT_POS   = 0;
  localparam int PLTM_CTRL_FMT_LSB   = 1;
  localparam int PLTM_CTRL_COLOR_POS = 3;
  localparam int PLTM_CTRL_W         = 4;
  localparam int PLTM_STAT_PTR_LSB   = 1;

  localparam logic [3:0]  PLTM_CTRL_RST   = 4'h0;
  localparam logic [10:0] PLTM_INDEX_RST  = 11'h000;
  localparam logic [10:0] PLTM_MAX_IN     = 11'h7FF;
  localparam logic        PLTM_SEL_USER   = 1'h0;
  localparam int          PLTM_DEF_SHIFT  = 2;
  localparam int          PLTM_PAD_12     = 3;
  localparam int          PLTM_PAD_16     = 7;

  typedef enum logic [1:0] {
    PLTM_FMT_8,
    PLTM_FMT_12,
    PLTM_FMT_16
  } pltm_fmt_t;

  typedef struct packed {
    logic                        valid;
    logic [2:0][PLTM_PIX_W-1:0]  chan;
  } pltm_pix_t;

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [PLTM_ADDR_W-1:0]  addr;
    logic [PLTM_DATA_W-1:0]  wdata;
  } pltm_bus_t;
endpackage

// *** verilog/pltm_mapper.sv ***
// Overview of operation
// - Map pixels through 11-bit-in, 9-bit-out table.
// - Clamp inputs above 2047 to final entry.
// - 8-bit format drops result's lowest bit.
// - 12-bit format appends three zero bits.
// - 16-bit format appends seven zero bits.
// - Reset loads linear table, output equals input/4.
// - User table contents revert on power cycle.
// - Only one user table is selectable.
// - Coefficient writes affect pixels immediately.
// - Activate switches the table into pixel path.
// - Index selects entry reached by value port.
// - Value port reads or replaces indexed coefficient.
// - Bulk port reaches all coefficients without index.
// - RGB and YUV apply one table to all channels.
// - Mono and Bayer map a single channel.
// - Mapping works with every output format.
module pltm_mapper
  import pltm_pkg::*;
(
  // Clock and reset.
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_RST_B,
  // Register port.
  input  wire pltm_bus_t              I_BUS,
  output logic [PLTM_DATA_W-1:0]      O_RD_DATA,
  // Pixel stream.
  input  wire pltm_pix_t              I_PIX,
  output pltm_pix_t                   O_PIX
);

  logic [PLTM_OUT_W-1:0]  table_reg [PLTM_DEPTH];
  logic [PLTM_DEPTH-1:0]  tab_we;
  logic [PLTM_IN_W-1:0]   tab_waddr;
  logic [PLTM_OUT_W-1:0]  tab_wval;
  logic [PLTM_CTRL_W-1:0] ctrl_reg;
  logic [PLTM_CTRL_W-1:0] ctrl_next;
  logic [PLTM_IN_W-1:0]   index_reg;
  logic [PLTM_IN_W-1:0]   index_next;
  logic [PLTM_IN_W-1:0]   bulk_ptr_reg;
  logic [PLTM_IN_W-1:0]   bulk_ptr_next;
  logic [PLTM_DATA_W-1:0] rd_data_reg;
  logic [PLTM_DATA_W-1:0] rd_data_next;
  pltm_pix_t              pix_reg;
  pltm_pix_t              pix_next;
  logic                   tab_active;
  logic                   tab_color;
  pltm_fmt_t              tab_fmt;

  assign tab_active = ctrl_reg[PLTM_CTRL_ACT_POS];
  assign tab_color  = ctrl_reg[PLTM_CTRL_COLOR_POS];
  assign tab_fmt    = pltm_fmt_t'(ctrl_reg[PLTM_CTRL_FMT_LSB +: 2]);

  // Table storage: one entry of flip-flops per index, reset to the linear map.
  for (genvar e = 0; e < PLTM_DEPTH; e++) begin : g_entry
    localparam logic [PLTM_OUT_W-1:0] ENTRY_RST = PLTM_OUT_W'(e >> PLTM_DEF_SHIFT);
    logic [PLTM_OUT_W-1:0] entry_next;
    always_comb begin
      entry_next = tab_we[e] ? tab_wval : table_reg[e];
    end
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        table_reg[e] <= ENTRY_RST;
      end else begin
        table_reg[e] <= entry_next;
      end
    end
  end

  // Register port decode and table write steering.
  always_comb begin
    ctrl_next     = ctrl_reg;
    index_next    = index_reg;
    bulk_ptr_next = bulk_ptr_reg;
    rd_data_next  = '0;
    tab_waddr     = index_reg;
    tab_wval      = I_BUS.wdata[PLTM_OUT_W-1:0];
    tab_we        = '0;
    if (I_BUS.wr) begin
      unique case (I_BUS.addr)
        PLTM_OFS_CTRL: begin
          ctrl_next = I_BUS.wdata[PLTM_CTRL_W-1:0];
        end
        PLTM_OFS_INDEX: begin
          index_next = I_BUS.wdata[PLTM_IN_W-1:0];
        end
        PLTM_OFS_VALUE: begin
          tab_we[tab_waddr] = 1'b1;
        end
        PLTM_OFS_BULK: begin
          tab_waddr             = bulk_ptr_reg;
          tab_we[tab_waddr]     = 1'b1;
          bulk_ptr_next         = bulk_ptr_reg + 11'h001;
        end
        PLTM_OFS_BULK_RST: begin
          bulk_ptr_next = '0;
        end
        default: begin
        end
      endcase
    end
    if (I_BUS.rd) begin
      unique case (I_BUS.addr)
        PLTM_OFS_CTRL: begin
          rd_data_next[PLTM_CTRL_W-1:0] = ctrl_reg;
        end
        PLTM_OFS_SELECT: begin
          rd_data_next[0] = PLTM_SEL_USER;
        end
        PLTM_OFS_INDEX: begin
          rd_data_next[PLTM_IN_W-1:0] = index_reg;
        end
        PLTM_OFS_VALUE: begin
          rd_data_next[PLTM_OUT_W-1:0] = table_reg[index_reg];
        end
        PLTM_OFS_BULK: begin
          rd_data_next[PLTM_OUT_W-1:0] = table_reg[bulk_ptr_reg];
          bulk_ptr_next                = bulk_ptr_reg + 11'h001;
        end
        PLTM_OFS_STATUS: begin
          rd_data_next[0]                                  = tab_active;
          rd_data_next[PLTM_STAT_PTR_LSB +: PLTM_IN_W]     = bulk_ptr_reg;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_reg     <= PLTM_CTRL_RST;
      index_reg    <= PLTM_INDEX_RST;
      bulk_ptr_reg <= PLTM_INDEX_RST;
      rd_data_reg  <= '0;
    end else begin
      ctrl_reg     <= ctrl_next;
      index_reg    <= index_next;
      bulk_ptr_reg <= bulk_ptr_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  // Clamp, look up and fit one channel to the output format.
  function automatic logic [PLTM_PIX_W-1:0] map_chan(input logic [PLTM_PIX_W-1:0] p);
    logic [PLTM_IN_W-1:0]  idx;
    logic [PLTM_OUT_W-1:0] res;
    idx = (p > PLTM_PIX_W'(PLTM_MAX_IN)) ? PLTM_MAX_IN : p[PLTM_IN_W-1:0];
    res = table_reg[idx];
    unique case (tab_fmt)
      PLTM_FMT_8:  map_chan = PLTM_PIX_W'(res[PLTM_OUT_W-1:1]);
      PLTM_FMT_12: map_chan = PLTM_PIX_W'({res, PLTM_PAD_12'(0)});
      PLTM_FMT_16: map_chan = {res, PLTM_PAD_16'(0)};
      default:     map_chan = {res, PLTM_PAD_16'(0)};
    endcase
  endfunction

  // Pixel path: one channel for mono and Bayer, three for RGB and YUV.
  always_comb begin
    pix_next       = '0;
    pix_next.valid = I_PIX.valid;
    for (int c = 0; c < PLTM_CHAN_N; c++) begin
      if (!tab_active) begin
        pix_next.chan[c] = I_PIX.chan[c];
      end else if (c == 0 || tab_color) begin
        pix_next.chan[c] = map_chan(I_PIX.chan[c]);
      end else begin
        pix_next.chan[c] = '0;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pix_reg <= '0;
    end else begin
      pix_reg <= pix_next;
    end
  end

  assign O_PIX     = pix_reg;
  assign O_RD_DATA = rd_data_reg;

  // Checks on the pixel path and the register port.
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);

  AST_CLAMP_TOP: assert property (
    I_PIX.valid && tab_active && tab_fmt == PLTM_FMT_16 && I_PIX.chan[0] > 16'h07FF
    |=> O_PIX.chan[0] == {$past(table_reg[PLTM_DEPTH-1]), 7'h00})
    else $error("Out of range pixel not clamped to last entry.");
  AST_FMT8: assert property (
    I_PIX.valid && tab_active && tab_fmt == PLTM_FMT_8 && I_PIX.chan[0] < 16'h0800
    |=> O_PIX.chan[0] == 16'($past(table_reg[I_PIX.chan[0][10:0]]) >> 1))
    else $error("Eight bit result not truncated.");
  AST_FMT12: assert property (
    I_PIX.valid && tab_active && tab_fmt == PLTM_FMT_12 && I_PIX.chan[0] < 16'h0800
    |=> O_PIX.chan[0] == {4'h0, $past(table_reg[I_PIX.chan[0][10:0]]), 3'h0})
    else $error("Twelve bit result misplaced.");
  AST_FMT16: assert property (
    I_PIX.valid && tab_active && tab_fmt == PLTM_FMT_16 && I_PIX.chan[0] < 16'h0800
    |=> O_PIX.chan[0] == {$past(table_reg[I_PIX.chan[0][10:0]]), 7'h00})
    else $error("Sixteen bit result misplaced.");
  AST_BYPASS: assert property (
    !tab_active |=> O_PIX == $past(I_PIX))
    else $error("Inactive table altered pixels.");
  AST_VALUE_RD: assert property (
    I_BUS.rd && I_BUS.addr == PLTM_OFS_VALUE
    |=> O_RD_DATA == 32'($past(table_reg[index_reg])))
    else $error("Value read returned wrong coefficient.");
  AST_VALUE_WR: assert property (
    I_BUS.wr && I_BUS.addr == PLTM_OFS_VALUE
    |=> table_reg[$past(index_reg)] == $past(I_BUS.wdata[8:0]))
    else $error("Value write did not reach the table.");
  AST_BULK_STEP: assert property (
    (I_BUS.wr || I_BUS.rd) && I_BUS.addr == PLTM_OFS_BULK
    |=> bulk_ptr_reg == $past(bulk_ptr_reg) + 11'h001 && index_reg == $past(index_reg))
    else $error("Bulk pointer did not advance alone.");
  AST_SELECT: assert property (
    I_BUS.rd && I_BUS.addr == PLTM_OFS_SELECT |=> O_RD_DATA == 32'h0000_0000)
    else $error("Selector reported a second table.");
  AST_COLOR_SAME: assert property (
    I_PIX.valid && tab_active && tab_color && I_PIX.chan[0] == I_PIX.chan[2]
    |=> O_PIX.chan[0] == O_PIX.chan[2])
    else $error("Channels mapped differently.");
  AST_MONO_ONE: assert property (
    tab_active && !tab_color |=> O_PIX.chan[1] == 16'h0000 && O_PIX.chan[2] == 16'h0000)
    else $error("Single channel mode drove extra channels.");

  // Further checks on the pixel path.
  AST_VALID_PASS: assert property (
    I_PIX.valid
    |=> O_PIX.valid)
    else $error("Valid beat lost in the pixel path.");
  AST_CLAMP_FMT8: assert property (
    I_PIX.valid && tab_active && tab_fmt == PLTM_FMT_8 && I_PIX.chan[0] > 16'h07FF
    |=> O_PIX.chan[0] == 16'($past(table_reg[PLTM_DEPTH-1]) >> 1))
    else $error("Eight bit pixel not clamped to last entry.");
  AST_CLAMP_FMT12: assert property (
    I_PIX.valid && tab_active && tab_fmt == PLTM_FMT_12 && I_PIX.chan[0] > 16'h07FF
    |=> O_PIX.chan[0] == {4'h0, $past(table_reg[PLTM_DEPTH-1]), 3'h0})
    else $error("Twelve bit pixel not clamped to last entry.");
  AST_FMT_SPARE: assert property (
    I_PIX.valid && tab_active && ctrl_reg[PLTM_CTRL_FMT_LSB +: 2] == 2'h3 && I_PIX.chan[0] < 16'h0800
    |=> O_PIX.chan[0] == {$past(table_reg[I_PIX.chan[0][10:0]]), 7'h00})
    else $error("Spare format code not mapped as sixteen bit.");
  AST_COLOR_MID: assert property (
    I_PIX.valid && tab_active && tab_color && I_PIX.chan[0] == I_PIX.chan[1]
    |=> O_PIX.chan[0] == O_PIX.chan[1])
    else $error("Middle channel mapped differently.");
  AST_COLOR_CLAMP: assert property (
    I_PIX.valid && tab_active && tab_color && tab_fmt == PLTM_FMT_16 && I_PIX.chan[2] > 16'h07FF
    |=> O_PIX.chan[2] == {$past(table_reg[PLTM_DEPTH-1]), 7'h00})
    else $error("Last channel not mapped through the table.");

  // Further checks on the register port.
  AST_RD_IDLE: assert property (
    !I_BUS.rd
    |=> O_RD_DATA == 32'h0000_0000)
    else $error("Read data stood without a read.");
  AST_UNMAPPED_RD: assert property (
    I_BUS.rd && I_BUS.addr > PLTM_OFS_STATUS
    |=> O_RD_DATA == 32'h0000_0000)
    else $error("Unmapped offset returned data.");
  AST_CTRL_WR: assert property (
    I_BUS.wr && I_BUS.addr == PLTM_OFS_CTRL
    |=> ctrl_reg == $past(I_BUS.wdata[3:0]))
    else $error("Control write not taken.");
  AST_CTRL_HOLD: assert property (
    !(I_BUS.wr && I_BUS.addr == PLTM_OFS_CTRL)
    |=> ctrl_reg == $past(ctrl_reg))
    else $error("Control changed without a control write.");
  AST_CTRL_RD: assert property (
    I_BUS.rd && I_BUS.addr == PLTM_OFS_CTRL
    |=> O_RD_DATA == 32'($past(ctrl_reg)))
    else $error("Control read returned wrong value.");
  AST_STATUS_RD: assert property (
    I_BUS.rd && I_BUS.addr == PLTM_OFS_STATUS
    |=> O_RD_DATA == {20'h0_0000, $past(bulk_ptr_reg), $past(tab_active)})
    else $error("Status read returned wrong value.");
  AST_INDEX_WR: assert property (
    I_BUS.wr && I_BUS.addr == PLTM_OFS_INDEX
    |=> index_reg == $past(I_BUS.wdata[10:0]))
    else $error("Index write not taken.");
  AST_INDEX_HOLD: assert property (
    !(I_BUS.wr && I_BUS.addr == PLTM_OFS_INDEX)
    |=> index_reg == $past(index_reg))
    else $error("Index changed without an index write.");
  AST_INDEX_RD: assert property (
    I_BUS.rd && I_BUS.addr == PLTM_OFS_INDEX
    |=> O_RD_DATA == 32'($past(index_reg)))
    else $error("Index read returned wrong value.");
  AST_BULK_WR: assert property (
    I_BUS.wr && I_BUS.addr == PLTM_OFS_BULK
    |=> table_reg[$past(bulk_ptr_reg)] == $past(I_BUS.wdata[8:0]))
    else $error("Bulk write did not reach the table.");
  AST_BULK_RD: assert property (
    I_BUS.rd && I_BUS.addr == PLTM_OFS_BULK
    |=> O_RD_DATA == 32'($past(table_reg[bulk_ptr_reg])))
    else $error("Bulk read returned wrong coefficient.");
  AST_BULK_CLEAR: assert property (
    I_BUS.wr && I_BUS.addr == PLTM_OFS_BULK_RST
    |=> bulk_ptr_reg == 11'h000)
    else $error("Bulk pointer not cleared.");
  AST_BULK_HOLD: assert property (
    !((I_BUS.wr || I_BUS.rd) && I_BUS.addr == PLTM_OFS_BULK) && !(I_BUS.wr && I_BUS.addr == PLTM_OFS_BULK_RST)
    |=> bulk_ptr_reg == $past(bulk_ptr_reg))
    else $error("Bulk pointer moved without a bulk access.");

  COV_FMT8_MAP: cover property (I_PIX.valid && tab_active && tab_fmt == PLTM_FMT_8);
  COV_COLOR_MAP: cover property (I_PIX.valid && tab_active && tab_color && tab_fmt == PLTM_FMT_12);
  COV_CLAMP: cover property (I_PIX.valid && tab_active && I_PIX.chan[0] > 16'h07FF);
  COV_LIVE_EDIT: cover property (tab_active && I_BUS.wr && I_BUS.addr == PLTM_OFS_VALUE);
  COV_SPARE_FMT: cover property (I_PIX.valid && tab_active && ctrl_reg[PLTM_CTRL_FMT_LSB +: 2] == 2'h3);

endmodule

// *** tb/pltm_pixel_src.sv ***
module pltm_pixel_src
  import pltm_pkg::*;
(
  // Clock.
  input  wire logic             i_clk,
  // Beat request from the bench.
  input  wire logic             i_send,
  input  wire logic [2:0][15:0] i_chan,
  // Pixel stream towards the mapper.
  output pltm_pix_t             o_pix
);
  timeunit 1ns;
  timeprecision 100ps;

  initial o_pix = '0;

  // Idle cycles invert the last channel values so stale data never passes for a beat.
  always @(posedge i_clk) begin
    if (i_send) begin
      o_pix <= '{valid: 1'b1, chan: i_chan};
    end else begin
      o_pix <= '{valid: 1'b0, chan: ~o_pix.chan};
    end
  end
endmodule

// *** tb/pixel_lookup_table_mapper_tb.sv ***
module pixel_lookup_table_mapper_tb
  import pltm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  pltm_bus_t        bus = '0;
  logic [31:0]      rdat;
  pltm_pix_t        pin;
  pltm_pix_t        pout;
  logic             send = 1'b0;
  logic [2:0][15:0] sch = '0;
  logic [8:0]       tab [2048];
  logic [3:0]       ctrl = 4'h0;
  logic [31:0]      rnd = 32'hc83f;
  int               errors = 0;
  int               total_checks = 0;

  pltm_mapper pltm_mapper_inst (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_BUS(bus), .O_RD_DATA(rdat),
                                .I_PIX(pin), .O_PIX(pout));
  pltm_pixel_src pltm_pixel_src_inst (.i_clk(clk), .i_send(send), .i_chan(sch), .o_pix(pin));

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected output of one channel from the control model and the table model.
  function automatic logic [15:0] fit(input logic [15:0] c, input logic on);
    logic [8:0] r;
    r = tab[(c > 16'h07FF) ? 11'h7FF : c[10:0]];
    if (!ctrl[0]) return c;
    if (!on) return 16'h0000;
    case (ctrl[2:1])
      2'h0: return {8'h00, r[8:1]};
      2'h1: return {4'h0, r, 3'h0};
      default: return {r, 7'h00};
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic conclude;
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    if (a == PLTM_OFS_CTRL) ctrl = d[3:0];
  endtask

  task automatic pix(input logic [2:0][15:0] c);
    @(posedge clk);
    send <= 1'b1;
    sch  <= c;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1;
    check(32'(pout.valid), 32'h1);
    for (int i = 0; i < 3; i++) check(32'(pout.chan[i]), 32'(fit(c[i], i == 0 || ctrl[3])));
  endtask

  task automatic do_reset(input int n);
    rst_b <= 1'b0;
    repeat (n) @(posedge clk);
    rst_b <= 1'b1;
    ctrl = 4'h0;
    for (int i = 0; i < 2048; i++) tab[i] = 9'(i >> 2);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude;
  end

  initial begin
    logic [31:0] v;
    do_reset(12);
    pix({16'h0FFF, 16'h1234, 16'h0007});
    for (int f = 0; f < 6; f++) begin
      wr(PLTM_OFS_CTRL, 32'({f[0], 2'(f >> 1), 1'b1}));
      pix({16'hFFFF, 16'h0800, 16'h07FF});
      repeat (6) begin
        rnd = lfsr(rnd);
        pix({rnd[15:0], rnd[31:16], rnd[26:11]});
      end
    end
    wr(PLTM_OFS_SELECT, 32'hFFFF_FFFF);
    acc(1'b0, PLTM_OFS_SELECT, 32'h0);
    check(rdat, 32'h0);
    wr(4'hF, 32'hFFFF_FFFF);
    acc(1'b0, 4'hF, 32'h0);
    check(rdat, 32'h0);
    acc(1'b0, PLTM_OFS_CTRL, 32'h0);
    check(rdat, {28'h0, ctrl});
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      v = (k == 0) ? 32'h7FF : {21'h0, rnd[10:0]};
      wr(PLTM_OFS_CTRL, 32'h0);
      wr(PLTM_OFS_INDEX, v);
      acc(1'b0, PLTM_OFS_INDEX, 32'h0);
      check(rdat, {21'h0, v[10:0]});
      wr(PLTM_OFS_VALUE, {23'h0, rnd[24:16]});
      tab[v[10:0]] = rnd[24:16];
      acc(1'b0, PLTM_OFS_VALUE, 32'h0);
      check(rdat, {23'h0, rnd[24:16]});
      wr(PLTM_OFS_CTRL, 32'({k[0], 2'(k), 1'b1}));
      pix({3{v[15:0]}});
      wr(PLTM_OFS_VALUE, {23'h0, rnd[8:0]});
      tab[v[10:0]] = rnd[8:0];
      pix({3{v[15:0]}});
    end
    wr(PLTM_OFS_BULK_RST, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(PLTM_OFS_BULK, {23'h0, rnd[8:0]});
      tab[k] = rnd[8:0];
    end
    wr(PLTM_OFS_BULK_RST, 32'h0);
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, PLTM_OFS_BULK, 32'h0);
      check(rdat, {23'h0, tab[k]});
    end
    acc(1'b0, PLTM_OFS_STATUS, 32'h0);
    check(rdat, {20'h0, 11'h004, ctrl[0]});
    wr(PLTM_OFS_CTRL, 32'h9);
    pix({16'h0003, 16'h0002, 16'h0001});
    do_reset(3);
    wr(PLTM_OFS_CTRL, 32'h9);
    pix({16'h0003, 16'h0002, 16'h0001});
    conclude;
  end
endmodule
